// ### verilog/obs_pkg.sv
// Constants and carriers for the flexible second operand shifter.
// Assumes a single core clock domain and a decoder that supplies encoded fields.
package obs_pkg;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned AMT_W   = 8;
	localparam int unsigned IMM_W   = 12;
	localparam int unsigned CLK_MHZ = 10;
	localparam logic [7:0]  LEN_ZERO  = 8'h00;
	localparam logic [7:0]  LEN_WORD  = 8'h20;
	localparam logic [7:0]  LEN_TWO_W = 8'h40;
	localparam logic [31:0] IMM_SMALL = 32'h0000_00FF;
	localparam logic [1:0]  PAT_LOW   = 2'h1;
	localparam logic [1:0]  PAT_HIGH  = 2'h2;
	localparam logic [1:0]  PAT_ALL   = 2'h3;
	localparam logic [2:0]  ROT_MIN   = 3'h4;

	typedef enum logic [2:0] {
		SHT_LSL = 3'h0,
		SHT_LSR = 3'h1,
		SHT_ASR = 3'h2,
		SHT_ROR = 3'h3,
		SHT_RRX = 3'h4
	} obs_shift_t;

	// One operand request from the decoder
	typedef struct packed {
		logic                  use_imm;
		logic [IMM_W-1:0]      imm_code;
		logic [DATA_W-1:0]     shift_source_register;
		obs_shift_t            shift_type;
		logic [AMT_W-1:0]      shift_len;
		logic                  set_flags;
		logic                  carry_in;
	} obs_req_t;

	// Answer to the ALU and flag logic
	typedef struct packed {
		logic [DATA_W-1:0]     flexible_second_operand;
		logic                  carry_out;
		logic                  carry_write;
	} obs_rsp_t;
endpackage : obs_pkg

// ### verilog/obs_shifter.sv
// Flexible second operand: immediate expander and register barrel shifter.
// Assumes requests are synchronous to core_clk; answer registered one cycle later.
//
// Contract
// (RULE1) Immediate is 8-bit value shifted anywhere, or byte replicated three patterns.
// (RULE2) Flag-setting shifted immediate above 255 sets carry to its bit 31.
// (RULE3) Shift lengths: ASR/LSR 1..32, LSL/ROR 1..31, RRX one bit.
// (RULE4) No shift or left shift zero passes source unchanged.
// (RULE5) Shifted value goes to consumer only; source register untouched.
// (RULE6) Length zero leaves carry; nonzero register shift updates carry with flags.
// (RULE7) Arithmetic right fills vacated upper bits with sign.
// (RULE8) Arithmetic right carry is source bit n-1.
// (RULE9) Arithmetic right 32 or more gives all sign bits and sign carry.
// (RULE10) Logical right zero-fills top; carry is source bit n-1.
// (RULE11) Logical shifts of 32+ give zero; 33+ write carry zero.
// (RULE12) Logical left zero-fills bottom; carry is source bit 32-n.
// (RULE13) Rotate right moves low n bits to top; carry bit n-1.
// (RULE14) Rotate 32 returns source, carry bit 31; above 32 uses n-32.
// (RULE15) Rotate through carry inserts carry at top; carry takes bit 0.
// (RULE16) Serves standalone shift instructions and second-operand shifts alike.
// (RULE17) Addresses loaded into the program counter must have bit 0 set.
// (RULE18) Length exactly 32: logical right carry bit 31, left carry bit 0.
`timescale 1ns/1ps
`default_nettype none
module obs_shifter (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	input  wire obs_pkg::obs_req_t req,
	output var  logic              rsp_valid,
	output var  obs_pkg::obs_rsp_t rsp
);
	logic              rsp_valid_ff;
	logic              nxt_rsp_valid;
	obs_pkg::obs_rsp_t rsp_ff;
	obs_pkg::obs_rsp_t nxt_rsp;

	logic [31:0] src;
	logic [7:0]  len;
	logic [7:0]  rlen;
	logic [63:0] dbl;
	logic [31:0] res;
	logic        cy;
	logic        cyw;
	logic [31:0] imm;
	logic [7:0]  byt;
	logic [4:0]  rot;

	always_comb begin
		src = req.shift_source_register; // RULE5
		len = req.shift_len;
		byt = req.imm_code[7:0];
		rot = req.imm_code[11:7];
		imm = 32'h0000_0000;
		rlen = len;
		dbl = 64'h0000_0000_0000_0000;
		res = src;
		cy = req.carry_in;
		cyw = 1'b0;
		if (req.use_imm) begin
			// Immediate path (RULE1)
			if (req.imm_code[11:10] == 2'h0) begin
				unique case (req.imm_code[9:8])
					2'h0:     imm = {24'h00_0000, byt};
					obs_pkg::PAT_LOW:  imm = {8'h00, byt, 8'h00, byt}; // RULE1
					obs_pkg::PAT_HIGH: imm = {byt, 8'h00, byt, 8'h00}; // RULE1
					obs_pkg::PAT_ALL:  imm = {byt, byt, byt, byt}; // RULE1
				endcase
			end else begin
				dbl = {32'h0000_0000, 24'h00_0000, 1'b1, req.imm_code[6:0]};
				imm = dbl[31:0] >> rot | dbl[31:0] << (6'd32 - {1'b0, rot});
			end
			res = imm;
			// Only shifted forms touch carry (RULE2)
			if (req.set_flags && req.imm_code[11:10] != 2'h0 && imm > obs_pkg::IMM_SMALL) begin
				cy = imm[31]; // RULE2
				cyw = 1'b1;
			end
		end else if (req.shift_type == obs_pkg::SHT_RRX) begin
			res = {req.carry_in, src[31:1]}; // RULE15
			cy = src[0]; // RULE15
			cyw = req.set_flags; // RULE3
		end else if (len != obs_pkg::LEN_ZERO) begin // RULE4 RULE6
			cyw = req.set_flags; // RULE6 RULE16
			unique case (req.shift_type)
				obs_pkg::SHT_LSL: begin
					if (len >= obs_pkg::LEN_WORD) begin
						res = 32'h0000_0000; // RULE11
						cy = (len == obs_pkg::LEN_WORD) ? src[0] : 1'b0; // RULE18 RULE11
					end else begin
						dbl = {32'h0000_0000, src} << len[4:0];
						res = dbl[31:0]; // RULE12
						cy = dbl[32]; // RULE12
					end
				end
				obs_pkg::SHT_LSR: begin
					if (len >= obs_pkg::LEN_WORD) begin
						res = 32'h0000_0000; // RULE11
						cy = (len == obs_pkg::LEN_WORD) ? src[31] : 1'b0; // RULE18 RULE11
					end else begin
						dbl = {src, 32'h0000_0000} >> len[4:0];
						res = dbl[63:32]; // RULE10
						cy = dbl[31]; // RULE10
					end
				end
				obs_pkg::SHT_ASR: begin
					if (len >= obs_pkg::LEN_WORD) begin
						res = {32{src[31]}}; // RULE9
						cy = src[31]; // RULE9
					end else begin
						dbl = $signed({src, 32'h0000_0000}) >>> len[4:0];
						res = dbl[63:32]; // RULE7
						cy = dbl[31]; // RULE8
					end
				end
				obs_pkg::SHT_ROR: begin
					// Lengths above 32 fold down by 32 repeatedly (RULE14)
					rlen = {3'h0, len[4:0]};
					if (rlen == obs_pkg::LEN_ZERO) begin
						res = src; // RULE14
						cy = src[31]; // RULE14
					end else begin
						dbl = {src, src} >> rlen[4:0];
						res = dbl[31:0]; // RULE13
						cy = src[rlen[4:0] - 5'd1]; // RULE13
					end
				end
				default: begin
					res = src;
					cyw = 1'b0;
				end
			endcase
		end
		nxt_rsp.flexible_second_operand = res;
		nxt_rsp.carry_out = cyw ? cy : req.carry_in; // RULE6
		nxt_rsp.carry_write = cyw;
		nxt_rsp_valid = req_valid;
		if (!rst_n) begin
			nxt_rsp = '0;
			nxt_rsp_valid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		rsp_ff <= nxt_rsp;
		rsp_valid_ff <= nxt_rsp_valid;
	end

	assign rsp = rsp_ff;
	assign rsp_valid = rsp_valid_ff;

	property p_pass;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSL && req.shift_len == 8'h00)
		|=> rsp.flexible_second_operand == $past(req.shift_source_register) && !rsp.carry_write;
	endproperty
	a_pass: assert property (p_pass) else $error("Zero shift altered operand"); // RULE4

	property p_zero_carry;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type != obs_pkg::SHT_RRX && req.shift_len == 8'h00)
		|=> rsp.carry_out == $past(req.carry_in);
	endproperty
	a_zero_carry: assert property (p_zero_carry) else $error("Zero shift changed carry"); // RULE6

	property p_asr_big;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ASR && req.shift_len >= 8'h20)
		|=> rsp.flexible_second_operand == {32{$past(req.shift_source_register[31])}};
	endproperty
	a_asr_big: assert property (p_asr_big) else $error("Wide ASR not sign fill"); // RULE9

	property p_lsr_big;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSR && req.shift_len > 8'h20
			&& req.set_flags) |=> rsp.flexible_second_operand == 32'h0000_0000 && !rsp.carry_out;
	endproperty
	a_lsr_big: assert property (p_lsr_big) else $error("Wide LSR not zero"); // RULE11

	property p_lsl_32;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSL && req.shift_len == 8'h20
			&& req.set_flags) |=> rsp.carry_out == $past(req.shift_source_register[0]);
	endproperty
	a_lsl_32: assert property (p_lsl_32) else $error("LSL 32 carry wrong"); // RULE18

	property p_rrx;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_RRX && req.set_flags)
		|=> rsp.flexible_second_operand[31] == $past(req.carry_in)
			&& rsp.carry_out == $past(req.shift_source_register[0]);
	endproperty
	a_rrx: assert property (p_rrx) else $error("RRX wrong"); // RULE15

	property p_ror_32;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ROR && req.shift_len == 8'h20)
		|=> rsp.flexible_second_operand == $past(req.shift_source_register);
	endproperty
	a_ror_32: assert property (p_ror_32) else $error("ROR 32 altered value"); // RULE14

	property p_imm_carry;
		@(posedge core_clk) disable iff (!rst_n)
		(req.use_imm && req.imm_code[11:10] == 2'h0)
		|=> !rsp.carry_write && rsp.carry_out == $past(req.carry_in);
	endproperty
	a_imm_carry: assert property (p_imm_carry) else $error("Pattern imm touched carry"); // RULE2

	property p_valid;
		@(posedge core_clk) disable iff (!rst_n)
		req_valid |=> rsp_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("Answer not one cycle later"); // RULE16

	// Mid-range lengths checked against plain shift operators, not the datapath
	property p_lsl_mid;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSL && req.shift_len != 8'h00 && req.shift_len < 8'h20)
		|=> rsp.flexible_second_operand == $past(req.shift_source_register << req.shift_len[4:0]);
	endproperty
	a_lsl_mid: assert property (p_lsl_mid) else $error("LSL value wrong"); // RULE12

	property p_lsl_mid_cy;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSL && req.shift_len != 8'h00
			&& req.shift_len < 8'h20 && req.set_flags)
		|=> rsp.carry_out == $past(req.shift_source_register[5'h00 - req.shift_len[4:0]]);
	endproperty
	a_lsl_mid_cy: assert property (p_lsl_mid_cy) else $error("LSL carry wrong"); // RULE12

	property p_lsr_mid;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSR && req.shift_len != 8'h00 && req.shift_len < 8'h20)
		|=> rsp.flexible_second_operand == $past(req.shift_source_register >> req.shift_len[4:0]);
	endproperty
	a_lsr_mid: assert property (p_lsr_mid) else $error("LSR value wrong"); // RULE10

	property p_lsr_mid_cy;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSR && req.shift_len != 8'h00
			&& req.shift_len < 8'h20 && req.set_flags)
		|=> rsp.carry_out == $past(req.shift_source_register[req.shift_len[4:0] - 5'h01]);
	endproperty
	a_lsr_mid_cy: assert property (p_lsr_mid_cy) else $error("LSR carry wrong"); // RULE10

	property p_asr_mid;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ASR && req.shift_len != 8'h00 && req.shift_len < 8'h20)
		|=> rsp.flexible_second_operand == $past(32'($signed(req.shift_source_register) >>> req.shift_len[4:0]));
	endproperty
	a_asr_mid: assert property (p_asr_mid) else $error("ASR value wrong"); // RULE7

	property p_asr_mid_cy;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ASR && req.shift_len != 8'h00
			&& req.shift_len < 8'h20 && req.set_flags)
		|=> rsp.carry_out == $past(req.shift_source_register[req.shift_len[4:0] - 5'h01]);
	endproperty
	a_asr_mid_cy: assert property (p_asr_mid_cy) else $error("ASR carry wrong"); // RULE8

	property p_ror_mid;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ROR && req.shift_len[4:0] != 5'h00)
		|=> rsp.flexible_second_operand == $past((req.shift_source_register >> req.shift_len[4:0])
			| (req.shift_source_register << (6'd32 - {1'b0, req.shift_len[4:0]})));
	endproperty
	a_ror_mid: assert property (p_ror_mid) else $error("ROR value wrong"); // RULE13

	property p_ror_mid_cy;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_ROR && req.shift_len[4:0] != 5'h00 && req.set_flags)
		|=> rsp.carry_out == $past(req.shift_source_register[req.shift_len[4:0] - 5'h01]);
	endproperty
	a_ror_mid_cy: assert property (p_ror_mid_cy) else $error("ROR carry wrong"); // RULE13

	property p_lsr_32;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSR && req.shift_len == 8'h20 && req.set_flags)
		|=> rsp.carry_out == $past(req.shift_source_register[31]);
	endproperty
	a_lsr_32: assert property (p_lsr_32) else $error("LSR 32 carry wrong"); // RULE18

	property p_lsl_big;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSL && req.shift_len > 8'h20 && req.set_flags)
		|=> rsp.flexible_second_operand == 32'h0000_0000 && !rsp.carry_out;
	endproperty
	a_lsl_big: assert property (p_lsl_big) else $error("Wide LSL not zero"); // RULE11

	property p_lsr_word;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_LSR && req.shift_len >= 8'h20)
		|=> rsp.flexible_second_operand == 32'h0000_0000;
	endproperty
	a_lsr_word: assert property (p_lsr_word) else $error("LSR 32 not zero"); // RULE11

	// Rotated immediates: carry written exactly when the value exceeds one byte
	property p_imm_rot_cy;
		@(posedge core_clk) disable iff (!rst_n)
		(req.use_imm && req.imm_code[11:10] != 2'h0 && req.set_flags)
		|=> rsp.carry_write == (rsp.flexible_second_operand > 32'h0000_00FF)
			&& (!rsp.carry_write || rsp.carry_out == rsp.flexible_second_operand[31]);
	endproperty
	a_imm_rot_cy: assert property (p_imm_rot_cy) else $error("Immediate carry wrong"); // RULE2

	property p_imm_no_flags;
		@(posedge core_clk) disable iff (!rst_n)
		(req.use_imm && !req.set_flags)
		|=> !rsp.carry_write && rsp.carry_out == $past(req.carry_in);
	endproperty
	a_imm_no_flags: assert property (p_imm_no_flags) else $error("Immediate wrote carry"); // RULE2

	property p_pat_all;
		@(posedge core_clk) disable iff (!rst_n)
		(req.use_imm && req.imm_code[11:8] == 4'h3)
		|=> rsp.flexible_second_operand == {4{$past(req.imm_code[7:0])}};
	endproperty
	a_pat_all: assert property (p_pat_all) else $error("Replicated byte wrong"); // RULE1

	property p_pat_low;
		@(posedge core_clk) disable iff (!rst_n)
		(req.use_imm && req.imm_code[11:8] == 4'h1)
		|=> rsp.flexible_second_operand == {2{8'h00, $past(req.imm_code[7:0])}};
	endproperty
	a_pat_low: assert property (p_pat_low) else $error("Low pattern wrong"); // RULE1

	property p_rrx_val;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_type == obs_pkg::SHT_RRX)
		|=> rsp.flexible_second_operand[30:0] == $past(req.shift_source_register[31:1]);
	endproperty
	a_rrx_val: assert property (p_rrx_val) else $error("RRX value wrong"); // RULE15

	property p_carry_write;
		@(posedge core_clk) disable iff (!rst_n)
		(!req.use_imm && req.shift_len != 8'h00 && 3'(req.shift_type) < 3'h4)
		|=> rsp.carry_write == $past(req.set_flags);
	endproperty
	a_carry_write: assert property (p_carry_write) else $error("Carry write wrong"); // RULE6

	property p_reset;
		@(posedge core_clk)
		!rst_n |=> !rsp_valid && rsp == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("Reset answer not cleared"); // RULE16
endmodule : obs_shifter
`default_nettype wire

// ### bench/obs_decoder_model.sv
// Decoder-side model that presents operand requests to the shifter.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module obs_decoder_model (
	output var logic              req_valid,
	output var obs_pkg::obs_req_t req
);
	initial begin
		req_valid = 1'b0;
		req       = '0;
	end
	// Branch targets never pass here; the decoder keeps bit 0 set on them
	task automatic issue(input obs_pkg::obs_req_t r);
		req_valid = 1'b1;
		req       = r;
	endtask : issue
	// Idle fields flip so a stale request is never mistaken for a live one
	task automatic idle();
		req_valid = 1'b0;
		req       = ~req;
	endtask : idle
endmodule : obs_decoder_model
`default_nettype wire

// ### bench/obs_shifter_tb.sv
// Self-checking bench for the operand shifter, driven through the decoder model.
// Assumes one answer per request, registered one clock after it is taken.
`timescale 1ns/1ps
`default_nettype none
module obs_shifter_tb;
	logic              core_clk;
	logic              rst_n;
	logic              req_valid;
	logic              rsp_valid;
	logic              pend;
	obs_pkg::obs_req_t req;
	obs_pkg::obs_rsp_t rsp;
	obs_pkg::obs_rsp_t exp_rsp;
	int                n_mismatch = 0;
	int                checks_done = 0;
	int                cycles = 0;
	obs_shifter u_obs_shifter (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .rsp_valid(rsp_valid), .rsp(rsp));
	obs_decoder_model u_obs_decoder_model (.req_valid(req_valid), .req(req));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] rotr(input logic [31:0] x, input int m);
		return (x >> m) | (x << (32 - m));
	endfunction : rotr
	function automatic obs_pkg::obs_rsp_t model(input obs_pkg::obs_req_t r);
		logic [31:0] s;
		logic [31:0] v;
		logic [7:0]  b;
		logic        c;
		logic        w;
		int          n;
		s = r.shift_source_register;
		n = int'(r.shift_len);
		b = r.imm_code[7:0];
		v = s;
		c = 1'b0;
		w = (n != 0);
		if (r.use_imm) begin
			w = 1'b0;
			case (r.imm_code[11:8])
				4'h0: v = {24'h00_0000, b};
				4'h1: v = {8'h00, b, 8'h00, b};
				4'h2: v = {b, 8'h00, b, 8'h00};
				4'h3: v = {4{b}};
				default: begin
					v = rotr({24'h00_0000, 1'b1, r.imm_code[6:0]}, int'(r.imm_code[11:7]));
					c = v[31];
					w = (v > obs_pkg::IMM_SMALL);
				end
			endcase
		end else case (r.shift_type)
			obs_pkg::SHT_LSL: if (w) begin
				v = (n > 31) ? '0 : s << n;
				c = (n > 32) ? 1'b0 : (n == 32) ? s[0] : s[32-n];
			end
			obs_pkg::SHT_LSR: if (w) begin
				v = (n > 31) ? '0 : s >> n;
				c = (n > 32) ? 1'b0 : (n == 32) ? s[31] : s[n-1];
			end
			obs_pkg::SHT_ASR: if (w) begin
				v = (n > 31) ? {32{s[31]}} : 32'($signed(s) >>> n);
				c = (n > 31) ? s[31] : s[n-1];
			end
			obs_pkg::SHT_ROR: if (w) begin
				v = rotr(s, n % 32);
				c = s[(n + 31) % 32];
			end
			obs_pkg::SHT_RRX: begin
				v = {r.carry_in, s[31:1]};
				c = s[0];
				w = 1'b1;
			end
			default: w = 1'b0;
		endcase
		w = w & r.set_flags;
		return {v, w ? c : r.carry_in, w};
	endfunction : model
	task automatic chk_prev();
		if (pend) begin
			chk(64'(rsp.flexible_second_operand), 64'(exp_rsp.flexible_second_operand));
			chk(64'({rsp.carry_out, rsp.carry_write}), 64'({exp_rsp.carry_out, exp_rsp.carry_write}));
		end
		chk(64'(rsp_valid), 64'(pend));
	endtask : chk_prev
	task automatic step(input obs_pkg::obs_req_t r);
		@(negedge core_clk);
		chk_prev();
		u_obs_decoder_model.issue(r);
		exp_rsp = model(r);
		pend    = 1'b1;
	endtask : step
	task automatic test_immediate();
		logic [11:0] codes [8] = '{12'h0A5, 12'h15A, 12'h281, 12'h3FF,
			12'h47F, 12'h800, 12'hFFF, 12'hC3C};
		foreach (codes[i]) step('{1'b1, codes[i], '0, obs_pkg::SHT_LSL, 8'h00, 1'b1, i[0]});
		$display("test_immediate done");
	endtask : test_immediate
	task automatic test_register_shifts(input logic sf);
		logic [7:0]  lens [7] = '{8'h00, 8'h01, 8'h08, 8'h1F, 8'h20, 8'h21, 8'h40};
		logic [31:0] srcs [2] = '{32'h8000_0001, 32'h6C3A_96E4};
		for (int t = 0; t < 6; t++) begin
			foreach (lens[i]) foreach (srcs[j]) step('{1'b0, 12'h000, srcs[j],
				obs_pkg::obs_shift_t'(3'(t)), lens[i], sf, i[0] ^ j[0]});
		end
		$display("test_register_shifts done");
	endtask : test_register_shifts
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	initial begin
		rst_n = 1'b0;
		pend  = 1'b0;
		@(negedge core_clk);
		u_obs_decoder_model.issue('{1'b0, 12'h000, 32'hFFFF_FFFF, obs_pkg::SHT_RRX, 8'h01, 1'b1, 1'b1});
		@(negedge core_clk);
		chk(64'({rsp, rsp_valid}), 64'h0000_0000_0000_0000);
		u_obs_decoder_model.idle();
		rst_n = 1'b1;
		test_immediate();
		test_register_shifts(1'b1);
		test_register_shifts(1'b0);
		@(negedge core_clk);
		chk_prev();
		u_obs_decoder_model.idle();
		pend = 1'b0;
		@(negedge core_clk);
		chk_prev();
		finish_test();
	end
endmodule : obs_shifter_tb
`default_nettype wire
